// *** hdl/local_bus_map.svh ***
// widths, timing counts, reset values and digit counts of the multiplexed local bus controller
`ifndef LOCAL_BUS_MAP_SVH
`define LOCAL_BUS_MAP_SVH

// ----------------------------------------
// widths
// ----------------------------------------
`define DATA_W              8
`define ADDR_W              16
`define DISP_ADDR_W         6
`define TOUT_W              20
`define PH_W                4

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define CLK_MHZ             25
`define CLK_PERIOD_NS       40
`define STROBE_NS           120
`define STROBE_CYC          ((`STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SYNC_CYC            3
`define READ_CYC            (`STROBE_CYC + `SYNC_CYC)
`define VERIFY_TIMEOUT_US   10000
`define VERIFY_TIMEOUT_CYC  (`VERIFY_TIMEOUT_US * `CLK_MHZ)

// ----------------------------------------
// reset values and digit counts
// ----------------------------------------
`define BUS_RST_VAL         8'h00
`define DIGITS_3            4'h3
`define DIGITS_5            4'h5
`define DIGITS_8            4'h8

`endif

// *** hdl/local_bus_pkg.sv ***
// types of the multiplexed local bus controller
package local_bus_pkg;

    typedef enum logic [2:0] {
        OP_MEM_RD  = 3'h0,
        OP_MEM_WR  = 3'h1,
        OP_DISP_RD = 3'h2,
        OP_DISP_WR = 3'h3,
        OP_SW_RD   = 3'h4,
        OP_FETCH   = 3'h5
    } op_t;

    typedef enum logic [1:0] {
        DIG_3 = 2'h0,
        DIG_5 = 2'h1,
        DIG_8 = 2'h2
    } digits_t;

    typedef enum logic [7:0] {
        ST_IDLE    = 8'h01,
        ST_UPPER   = 8'h02,
        ST_SELECT  = 8'h04,
        ST_LOWER   = 8'h08,
        ST_HOLD    = 8'h10,
        ST_WRITE   = 8'h20,
        ST_READ    = 8'h40,
        ST_RELEASE = 8'h80
    } state_t;

endpackage

// *** hdl/bus_sample_if.sv ***
// carrier between the controller and its data bus input filter
`timescale 1ns/100ps
`default_nettype none
interface bus_sample_if;
    logic [7:0] raw;
    logic [7:0] stable;

    modport filt (
        input  raw,
        output stable
    );
    modport ctrl (
        output raw,
        input  stable
    );
endinterface
`default_nettype wire

// *** hdl/bus_input_filter.sv ***
// three-stage synchroniser and agreement filter for the shared data bus
`timescale 1ns/100ps
`default_nettype none
`include "local_bus_map.svh"
module bus_input_filter (
    // clock and reset
    input  wire logic     clk_i,
    input  wire logic     rst_b_i,
    // bus samples
    bus_sample_if.filt    sif
);
    logic [`DATA_W-1:0] s1_r;
    logic [`DATA_W-1:0] s2_r;
    logic [`DATA_W-1:0] s3_r;
    logic [`DATA_W-1:0] stable_r;

    // ----------------------------------------
    // synchroniser chain
    // ----------------------------------------
    // s1 feeds only s2, so it may go metastable safely
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s1_r <= `BUS_RST_VAL;
            s2_r <= `BUS_RST_VAL;
            s3_r <= `BUS_RST_VAL;
        end else begin
            s1_r <= sif.raw;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // ----------------------------------------
    // agreement
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            stable_r <= `BUS_RST_VAL;
        end else if (s2_r == s3_r) begin
            stable_r <= s3_r;
        end
    end

    assign sif.stable = stable_r;
endmodule
`default_nettype wire

// *** hdl/local_bus_ctrl.sv ***
// controller for the multiplexed address/data local bus
`timescale 1ns/100ps
`default_nettype none
`include "local_bus_map.svh"

module local_bus_ctrl #(
    parameter int unsigned VERIFY_TIMEOUT_CYC = `VERIFY_TIMEOUT_CYC
) (
    // clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   rst_b_i,
    // command port
    input  wire logic                   cmd_valid_i,
    input  wire local_bus_pkg::op_t     cmd_op_i,
    input  wire logic [`ADDR_W-1:0]     cmd_addr_i,
    input  wire logic [`DATA_W-1:0]     cmd_wdata_i,
    input  wire local_bus_pkg::digits_t cmd_digits_i,
    input  wire logic [`DATA_W-1:0]     cmd_stop_code_i,
    output var  logic                   cmd_ready_o,
    output var  logic                   busy_o,
    // answers
    output var  logic                   rsp_valid_o,
    output var  logic [`DATA_W-1:0]     rsp_data_o,
    output var  logic                   done_o,
    output var  logic                   timeout_o,
    // shared user bit
    input  wire logic                   display_enable_i,
    input  wire logic                   user_bit_seven_i,
    output var  logic                   user_bit_seven_o,
    // local bus pins
    input  wire logic [`DATA_W-1:0]     data_bus_i,
    output var  logic [`DATA_W-1:0]     data_bus_o,
    output var  logic                   data_bus_oe_o,
    output var  logic                   ale_o,
    output var  logic                   rd_n_o,
    output var  logic                   wr_n_o,
    output var  logic                   ext_mem_select_n_o,
    output var  logic                   switch_select_n_o
);
    import local_bus_pkg::*;

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    state_t             state_r;
    state_t             state_nxt;
    op_t                op_r;
    op_t                op_nxt;
    logic [`ADDR_W-1:0] addr_r;
    logic [`ADDR_W-1:0] addr_nxt;
    logic [`DATA_W-1:0] wdata_r;
    logic [`DATA_W-1:0] stop_r;
    logic [`DATA_W-1:0] rdata_r;
    logic [3:0]         digits_left_r;
    logic               verify_r;
    logic [`PH_W-1:0]   ph_r;
    logic [`TOUT_W-1:0] tout_cnt_r;
    logic               tout_hit;
    logic               adv;
    logic               is_mem;
    logic               sel_phase;
    logic               to_idle;
    logic               read_end;
    logic [`DATA_W-1:0] low_byte;
    logic               disp_sel_n;

    bus_sample_if sif ();

    bus_input_filter u_filter (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .sif     (sif)
    );

    assign sif.raw = data_bus_i;

    // ----------------------------------------
    // sequencing
    // ----------------------------------------
    assign adv      = (ph_r == '0);
    assign tout_hit = (tout_cnt_r >= VERIFY_TIMEOUT_CYC[`TOUT_W-1:0]);
    assign read_end = (state_r == ST_READ) && adv;
    assign to_idle  = (state_r != ST_IDLE) && (state_nxt == ST_IDLE);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (cmd_valid_i) begin
                    if (cmd_op_i == OP_MEM_RD || cmd_op_i == OP_MEM_WR || cmd_op_i == OP_FETCH) begin
                        state_nxt = ST_UPPER;
                    end else begin
                        state_nxt = ST_SELECT;
                    end
                end
            end
            ST_UPPER: begin
                if (adv) begin
                    state_nxt = ST_SELECT;
                end
            end
            ST_SELECT: begin
                if (adv) begin
                    state_nxt = ST_LOWER;
                end
            end
            ST_LOWER: begin
                if (adv) begin
                    state_nxt = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (adv) begin
                    // switch reads never reach the write phase
                    if ((op_r == OP_MEM_WR && !verify_r) || op_r == OP_DISP_WR) begin
                        state_nxt = ST_WRITE;
                    end else begin
                        state_nxt = ST_READ;
                    end
                end
            end
            ST_WRITE: begin
                if (adv) begin
                    state_nxt = ST_RELEASE;
                end
            end
            ST_READ: begin
                if (adv) begin
                    if (op_r == OP_SW_RD && digits_left_r != 4'h1) begin
                        state_nxt = ST_LOWER;
                    end else begin
                        state_nxt = ST_RELEASE;
                    end
                end
            end
            ST_RELEASE: begin
                if (adv) begin
                    if (op_r == OP_MEM_WR && !verify_r) begin
                        state_nxt = ST_UPPER;
                    end else if (op_r == OP_MEM_WR && rdata_r != wdata_r && !tout_hit) begin
                        state_nxt = ST_UPPER;
                    end else if (op_r == OP_FETCH && rdata_r != stop_r) begin
                        state_nxt = ST_UPPER;
                    end else begin
                        state_nxt = ST_IDLE;
                    end
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // phase length: read phase waits out the input synchroniser
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ph_r <= '0;
        end else if (state_nxt != state_r) begin
            if (state_nxt == ST_READ) begin
                ph_r <= `PH_W'(`READ_CYC - 1);
            end else begin
                ph_r <= `PH_W'(`STROBE_CYC - 1);
            end
        end else if (ph_r != '0) begin
            ph_r <= ph_r - `PH_W'(1);
        end
    end

    // ----------------------------------------
    // transfer context
    // ----------------------------------------
    always_comb begin
        op_nxt   = op_r;
        addr_nxt = addr_r;
        if (state_r == ST_IDLE && cmd_valid_i) begin
            op_nxt   = cmd_op_i;
            addr_nxt = cmd_addr_i;
        end else if (read_end && op_r == OP_SW_RD) begin
            addr_nxt = {addr_r[`ADDR_W-1:8], addr_r[7:0] + 8'h01};
        end else if (state_r == ST_RELEASE && adv && op_r == OP_FETCH) begin
            addr_nxt = addr_r + `ADDR_W'(1);
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            op_r    <= OP_MEM_RD;
            addr_r  <= '0;
            wdata_r <= '0;
            stop_r  <= '0;
        end else begin
            op_r   <= op_nxt;
            addr_r <= addr_nxt;
            if (state_r == ST_IDLE && cmd_valid_i) begin
                wdata_r <= cmd_wdata_i;
                stop_r  <= cmd_stop_code_i;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            digits_left_r <= '0;
        end else if (state_r == ST_IDLE && cmd_valid_i) begin
            case (cmd_digits_i)
                DIG_3:   digits_left_r <= `DIGITS_3;
                DIG_5:   digits_left_r <= `DIGITS_5;
                DIG_8:   digits_left_r <= `DIGITS_8;
                default: digits_left_r <= `DIGITS_8;
            endcase
        end else if (read_end && op_r == OP_SW_RD) begin
            digits_left_r <= digits_left_r - 4'h1;
        end
    end

    // ----------------------------------------
    // write verify
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            verify_r <= 1'b0;
        end else if (state_r == ST_IDLE) begin
            verify_r <= 1'b0;
        end else if (state_r == ST_RELEASE && adv && op_r == OP_MEM_WR) begin
            verify_r <= 1'b1;
        end
    end

    // saturating, so a slow part cannot wrap it back into range
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tout_cnt_r <= '0;
        end else if (state_r == ST_IDLE) begin
            tout_cnt_r <= '0;
        end else if (op_r == OP_MEM_WR && !tout_hit) begin
            tout_cnt_r <= tout_cnt_r + `TOUT_W'(1);
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_r <= '0;
        end else if (read_end) begin
            rdata_r <= sif.stable;
        end
    end

    // ----------------------------------------
    // answers
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rsp_valid_o <= 1'b0;
            rsp_data_o  <= '0;
        end else begin
            rsp_valid_o <= read_end && !(op_r == OP_MEM_WR);
            if (read_end) begin
                rsp_data_o <= sif.stable;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            done_o    <= 1'b0;
            timeout_o <= 1'b0;
        end else begin
            done_o <= to_idle;
            if (to_idle) begin
                timeout_o <= (op_r == OP_MEM_WR) && (rdata_r != wdata_r);
            end
        end
    end

    // busy covers fetch too, keeping the command source off the bus
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            busy_o      <= 1'b0;
            cmd_ready_o <= 1'b0;
        end else begin
            busy_o      <= (state_nxt != ST_IDLE);
            cmd_ready_o <= (state_nxt == ST_IDLE);
        end
    end

    // ----------------------------------------
    // pin drive
    // ----------------------------------------
    assign is_mem    = (op_nxt == OP_MEM_RD) || (op_nxt == OP_MEM_WR) || (op_nxt == OP_FETCH);
    assign sel_phase = (state_nxt == ST_SELECT) || (state_nxt == ST_LOWER) || (state_nxt == ST_HOLD)
                    || (state_nxt == ST_WRITE) || (state_nxt == ST_READ);
    assign disp_sel_n = !(sel_phase && (op_nxt == OP_DISP_RD || op_nxt == OP_DISP_WR));

    always_comb begin
        if (op_nxt == OP_DISP_RD || op_nxt == OP_DISP_WR) begin
            low_byte = {2'b00, addr_nxt[`DISP_ADDR_W-1:0]};
        end else begin
            low_byte = addr_nxt[7:0];
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            data_bus_o    <= '0;
            data_bus_oe_o <= 1'b0;
        end else begin
            case (state_nxt)
                ST_UPPER: begin
                    data_bus_o    <= addr_nxt[15:8];
                    data_bus_oe_o <= 1'b1;
                end
                ST_SELECT: begin
                    data_bus_o    <= addr_nxt[15:8];
                    data_bus_oe_o <= is_mem;
                end
                ST_LOWER, ST_HOLD: begin
                    data_bus_o    <= low_byte;
                    data_bus_oe_o <= 1'b1;
                end
                ST_WRITE: begin
                    data_bus_o    <= wdata_r;
                    data_bus_oe_o <= 1'b1;
                end
                default: begin
                    data_bus_o    <= '0;
                    data_bus_oe_o <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ale_o  <= 1'b0;
            rd_n_o <= 1'b1;
            wr_n_o <= 1'b1;
        end else begin
            ale_o  <= (state_nxt == ST_LOWER);
            rd_n_o <= !(state_nxt == ST_READ);
            wr_n_o <= !(state_nxt == ST_WRITE) || (op_nxt == OP_SW_RD);
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ext_mem_select_n_o <= 1'b1;
            switch_select_n_o  <= 1'b1;
        end else begin
            ext_mem_select_n_o <= !(sel_phase && is_mem);
            switch_select_n_o  <= !(sel_phase && op_nxt == OP_SW_RD);
        end
    end

    // pin is plain user output unless the display is in use
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            user_bit_seven_o <= 1'b1;
        end else if (display_enable_i) begin
            user_bit_seven_o <= disp_sel_n;
        end else begin
            user_bit_seven_o <= user_bit_seven_i;
        end
    end

endmodule
`default_nettype wire

// *** verif/local_bus_ctrl_sva.sv ***
// assertion checker for the multiplexed local bus controller
`timescale 1ns/100ps
`default_nettype none
`include "local_bus_map.svh"
module local_bus_ctrl_sva #(
    parameter int unsigned VERIFY_TIMEOUT_CYC = 40
) (
    // clock, reset and status
    input wire logic               clk_i,
    input wire logic               rst_b_i,
    input wire logic               busy_o,
    input wire logic               done_o,
    // shared user bit
    input wire logic               display_enable_i,
    input wire logic               user_bit_seven_i,
    input wire logic               user_bit_seven_o,
    // local bus pins
    input wire logic [`DATA_W-1:0] data_bus_o,
    input wire logic               data_bus_oe_o,
    input wire logic               ale_o,
    input wire logic               rd_n_o,
    input wire logic               wr_n_o,
    input wire logic               ext_mem_select_n_o,
    input wire logic               switch_select_n_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    chk_read_floats: assert property (!rd_n_o |-> !data_bus_oe_o)
        else $error("bus driven during read strobe");
    chk_write_drives: assert property (!wr_n_o && $past(!wr_n_o) |-> data_bus_oe_o && $stable(data_bus_o))
        else $error("write data not held under write strobe");
    chk_ale_pulse: assert property ($rose(ale_o) |-> (ale_o && data_bus_oe_o) [*3] ##1 !ale_o)
        else $error("latch strobe not a driven three cycle pulse");
    chk_ale_selected: assert property ($rose(ale_o) |->
        !ext_mem_select_n_o || !switch_select_n_o || (display_enable_i && !user_bit_seven_o))
        else $error("latch strobe with no target selected");
    chk_no_switch_write: assert property (!switch_select_n_o |-> wr_n_o)
        else $error("write strobe during switch select");
    chk_write_verify: assert property ($fell(wr_n_o) && !ext_mem_select_n_o |->
        ##[4:40] (!rd_n_o && !ext_mem_select_n_o))
        else $error("no verify read after memory write");
    chk_busy_write: assert property ($fell(wr_n_o) && !ext_mem_select_n_o |-> busy_o [*8])
        else $error("busy dropped during memory write");
    chk_done_released: assert property (done_o |-> ext_mem_select_n_o && switch_select_n_o && rd_n_o
        && wr_n_o && (user_bit_seven_o || !display_enable_i))
        else $error("select or strobe still active at done");
    chk_disp_addr: assert property (ale_o && display_enable_i && !user_bit_seven_o |-> data_bus_o[7:6] == 2'h0)
        else $error("display address beyond six bits");
    chk_user_bit: assert property (!display_enable_i && $past(!display_enable_i) && $past(rst_b_i)
        |-> user_bit_seven_o == $past(user_bit_seven_i))
        else $error("user bit not passed through");
endmodule

bind local_bus_ctrl local_bus_ctrl_sva #(.VERIFY_TIMEOUT_CYC(VERIFY_TIMEOUT_CYC)) u_sva (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .busy_o(busy_o), .done_o(done_o),
    .display_enable_i(display_enable_i), .user_bit_seven_i(user_bit_seven_i),
    .user_bit_seven_o(user_bit_seven_o), .data_bus_o(data_bus_o), .data_bus_oe_o(data_bus_oe_o),
    .ale_o(ale_o), .rd_n_o(rd_n_o), .wr_n_o(wr_n_o), .ext_mem_select_n_o(ext_mem_select_n_o),
    .switch_select_n_o(switch_select_n_o));
`default_nettype wire

// *** verif/bus_partner_model.sv ***
// memory, address latches, display and switches on the local bus
`timescale 1ns/100ps
`default_nettype none
module bus_partner_model (
    // clock
    input  wire logic        clk_i,
    // controller pins
    input  wire logic [7:0]  dq_i,
    input  wire logic        oe_i,
    input  wire logic        ale_i,
    input  wire logic        rd_n_i,
    input  wire logic        wr_n_i,
    input  wire logic        mem_sel_n_i,
    input  wire logic        disp_sel_n_i,
    input  wire logic        switch_select_n_n_i,
    // reads that still show the inverted byte after a write
    input  wire logic [15:0] poll_i,
    // resolved bus level
    output logic [7:0]       dq_o
);
    logic [7:0]  mem [0:65535];
    logic [7:0]  disp [0:63];
    logic [7:0]  hi_r;
    logic [7:0]  lo_r;
    logic [15:0] pend_r = 16'h0000;
    logic        rd_q_r = 1'b1;
    logic        disp_ce;
    logic [7:0]  mem_q;
    // select alone is not an enable: gated by the strobes
    assign disp_ce = !disp_sel_n_i && !(rd_n_i && wr_n_i);
    // polling part shows inverted data until its write finishes
    assign mem_q = (pend_r != 16'h0000) ? ~mem[{hi_r, lo_r}] : mem[{hi_r, lo_r}];
    // pull-ups hold the bus high when nobody drives it
    assign dq_o = oe_i ? dq_i : rd_n_i ? 8'hff : !mem_sel_n_i ? mem_q :
                  disp_ce ? disp[lo_r[5:0]] : !switch_select_n_n_i ? (lo_r ^ 8'h3c) : 8'hff;
    always @(posedge clk_i) begin
        rd_q_r <= rd_n_i;
        if (mem_sel_n_i && oe_i)
            hi_r <= dq_i;
        if (ale_i)
            lo_r <= dq_i;
        if (!wr_n_i && !mem_sel_n_i) begin
            mem[{hi_r, lo_r}] <= dq_i;
            pend_r <= poll_i;
        end else if (rd_n_i && !rd_q_r && pend_r != 16'h0000)
            pend_r <= pend_r - 16'h0001;
        if (!wr_n_i && disp_ce)
            disp[lo_r[5:0]] <= dq_i;
    end
endmodule
`default_nettype wire

// *** verif/local_muxed_bus_controller_tb_top.sv ***
// self-checking testbench of the multiplexed local bus controller
`timescale 1ns/100ps
`default_nettype none
module local_muxed_bus_controller_tb_top;
    import local_bus_pkg::*;
    localparam int unsigned TOUT = 200;
    logic clk_i = 0, rst_b_i = 0, cmd_valid_i = 0, display_enable_i = 1, user_bit_seven_i = 1;
    op_t cmd_op_i = OP_MEM_RD;
    digits_t cmd_digits_i = DIG_3;
    logic [15:0] cmd_addr_i = 16'h0000, poll = 16'h0000, seed = 16'h666a, a;
    logic [7:0] cmd_wdata_i = 8'h00, cmd_stop_code_i = 8'ha5, data_bus_i, data_bus_o, rsp_data_o, d;
    logic cmd_ready_o, busy_o, rsp_valid_o, done_o, timeout_o, user_bit_seven_o;
    logic data_bus_oe_o, ale_o, rd_n_o, wr_n_o, ext_mem_select_n_o, switch_select_n_o;
    logic [7:0] rq [$];
    int failures = 0, samples_checked = 0;

    always #20 clk_i = ~clk_i;

    local_bus_ctrl #(.VERIFY_TIMEOUT_CYC(TOUT)) DUT (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i),
        .cmd_addr_i(cmd_addr_i), .cmd_wdata_i(cmd_wdata_i), .cmd_digits_i(cmd_digits_i),
        .cmd_stop_code_i(cmd_stop_code_i), .cmd_ready_o(cmd_ready_o), .busy_o(busy_o),
        .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .done_o(done_o), .timeout_o(timeout_o),
        .display_enable_i(display_enable_i), .user_bit_seven_i(user_bit_seven_i),
        .user_bit_seven_o(user_bit_seven_o), .data_bus_i(data_bus_i), .data_bus_o(data_bus_o),
        .data_bus_oe_o(data_bus_oe_o), .ale_o(ale_o), .rd_n_o(rd_n_o), .wr_n_o(wr_n_o),
        .ext_mem_select_n_o(ext_mem_select_n_o), .switch_select_n_o(switch_select_n_o));

    bus_partner_model u_far (
        .clk_i(clk_i), .dq_i(data_bus_o), .oe_i(data_bus_oe_o), .ale_i(ale_o), .rd_n_i(rd_n_o),
        .wr_n_i(wr_n_o), .mem_sel_n_i(ext_mem_select_n_o), .disp_sel_n_i(user_bit_seven_o),
        .switch_select_n_n_i(switch_select_n_o), .poll_i(poll), .dq_o(data_bus_i));

    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask

    task automatic print_verdict;
        $display("compared %0d mismatched %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // one command, replies gathered until done; bounded so a hang still ends
    task automatic run(input op_t op, input logic [15:0] ad, input logic [7:0] wd, input digits_t dg);
        int n;
        rq.delete();
        n = 0;
        while (cmd_ready_o !== 1'b1 && n < 100) begin
            @(posedge clk_i);
            #1 n++;
        end
        cmd_op_i = op;
        cmd_addr_i = ad;
        cmd_wdata_i = wd;
        cmd_digits_i = dg;
        cmd_valid_i = 1'b1;
        @(posedge clk_i);
        #1 cmd_valid_i = 1'b0;
        chk1(busy_o, 1'b1);
        n = 0;
        while (done_o !== 1'b1 && n < 3000) begin
            @(posedge clk_i);
            #1 n++;
            if (rsp_valid_o === 1'b1)
                rq.push_back(rsp_data_o);
        end
        chk1(done_o, 1'b1);
    endtask

    task automatic wr_rd(input logic [15:0] ad, input logic [7:0] wd);
        run(OP_MEM_WR, ad, wd, DIG_3);
        chk1(timeout_o, 1'b0);
        run(OP_MEM_RD, ad, 8'h00, DIG_3);
        chk8(8'(rq.size()), 8'h01);
        chk8(rq[0], wd);
    endtask

    initial begin
        // long enough for all tests with ample margin
        #(40 * 40000);
        failures++;
        print_verdict();
    end

    initial begin
        repeat (20) @(posedge clk_i);
        #1 rst_b_i = 1'b1;
        repeat (2) @(posedge clk_i);
        #1;
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            a = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : seed;
            seed = lfsr(seed);
            wr_rd(a, seed[7:0]);
        end
        $display("test ram done");
        poll = 16'h0003;
        wr_rd(seed ^ 16'h1234, 8'h5e);
        poll = 16'd1000;
        run(OP_MEM_WR, 16'h4321, 8'h77, DIG_3);
        chk1(timeout_o, 1'b1);
        poll = 16'h0000;
        wr_rd(16'h4321, 8'h88);
        $display("test verify done");
        seed = lfsr(seed);
        run(OP_DISP_WR, {10'h3ff, seed[5:0]}, seed[15:8], DIG_3);
        d = seed[15:8];
        run(OP_DISP_RD, {10'h3ff, seed[5:0]}, 8'h00, DIG_3);
        chk8(rq[0], d);
        $display("test display done");
        for (int k = 0; k < 3; k++) begin
            seed = lfsr(seed);
            run(OP_SW_RD, seed, 8'h00, digits_t'(k));
            d = (k == 0) ? 8'h03 : (k == 1) ? 8'h05 : 8'h08;
            chk8(8'(rq.size()), d);
            for (int j = 0; j < int'(d); j++)
                chk8(rq[j], (seed[7:0] + 8'(j)) ^ 8'h3c);
        end
        $display("test switches done");
        seed = lfsr(seed);
        a = {seed[15:2], 2'b00};
        wr_rd(a, 8'h11);
        wr_rd(a + 16'h0001, 8'h22);
        wr_rd(a + 16'h0002, 8'ha5);
        run(OP_FETCH, a, 8'h00, DIG_3);
        chk8(8'(rq.size()), 8'h03);
        chk8(rq[0], 8'h11);
        chk8(rq[1], 8'h22);
        chk8(rq[2], 8'ha5);
        $display("test fetch done");
        display_enable_i = 1'b0;
        for (int k = 0; k < 4; k++) begin
            user_bit_seven_i = seed[k];
            repeat (2) @(posedge clk_i);
            #1 chk1(user_bit_seven_o, seed[k]);
        end
        $display("test user bit done");
        print_verdict();
    end
endmodule
`default_nettype wire
